// ==== ppm_map.svh ====
// Constants for the pin pad and mode select block
// Summary of operation
// - Any internal reset source drives the reset pin low.
// - External low on reset pin resets the device; pin idles high by pullup.
// - In power-on or debug-forced reset the shared pin is mode select only.
// - When internal reset deasserts the shared pin becomes the debug pin.
// - In debug or mode-select duty the pin has pullup; output driver only in debug duty.
// - Debug link enabled whenever the background pin enable bit is set.
// - Every reset sets the enable bit; software clears it for port use.
// - Pin high at reset release starts normal operating mode.
// - Pin held low through reset starts active background mode.
// - Each debug link bit lasts sixteen debug clock cycles.
// - Debug clock may run at any rate up to the bus clock.
// - Debug pin is pseudo open drain with brief driven-high speedup pulses.
// - As port pin the shared pin is output only, no input or pullup.
// - Ports A, B, C bidirectional except output-only bit; per-bit pullups.
// - Output pins lose pullup except open-drain pins in two-wire duty.
// - Port A bits 2 and 3 only drive low as outputs.
// - Two-wire pullups stay on as outputs but cut off while driving low.
// - Crystal oscillator has an option to run in deep stop mode.
// - After reset all port pins are high impedance with pullups off.
`ifndef PPM_MAP_SVH
`define PPM_MAP_SVH
`define PPM_PORT_W 8
`define PPM_PORTS 3
`define PPM_PORT_A 0
`define PPM_OUT_ONLY_BIT 4
`define PPM_OD_DATA_BIT 2
`define PPM_OD_CLOCK_BIT 3
`define PPM_BIT_CYCLES 5'h10
`define PPM_ZERO8 8'h00
`endif

// ==== ppm_pad_ctrl.sv ====
// Pad control for reset pin, shared debug pin and general-purpose ports
`timescale 1ns/1ps
`include "ppm_map.svh"
module ppm_pad_ctrl (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic internal_reset_i,
    input wire logic reset_pin_i,
    input wire logic por_or_force_i,
    output logic reset_pin_o,
    output logic reset_pin_oe_n_o,
    output logic reset_pin_pullup_o,
    output logic device_reset_n_o,
    input wire logic background_mode_select_pin_i,
    output logic background_mode_select_pin_o,
    output logic background_mode_select_pin_oe_n_o,
    output logic bkgd_pullup_o,
    input wire logic background_pin_enable_bit_i,
    input wire logic bdc_drive_low_i,
    input wire logic bdc_speedup_i,
    output logic bdc_rx_o,
    output logic active_background_mode_o,
    output logic [4:0] bdc_bit_cycles_o,
    input wire logic comparator_output_sel_i,
    input wire logic comparator_output_i,
    input wire logic output_only_port_bit_i,
    input wire ppm_pkg::ppm_ports_type port_data_i,
    input wire ppm_pkg::ppm_ports_type port_dir_out_i,
    input wire ppm_pkg::ppm_ports_type port_pullup_en_i,
    input wire ppm_pkg::ppm_ports_type port_pin_i,
    input wire logic two_wire_serial_unit_en_i,
    output ppm_pkg::ppm_ports_type port_pin_o,
    output ppm_pkg::ppm_ports_type port_oe_n_o,
    output ppm_pkg::ppm_ports_type port_pullup_o,
    output ppm_pkg::ppm_ports_type port_in_o,
    input wire logic osc_stop_enable_i,
    input wire logic deep_stop_mode_i,
    output logic crystal_oscillator_run_o
);
    import ppm_pkg::*;
    ppm_state_type state_reg, state_next;
    logic rst_n;
    ppm_byte_type da [`PPM_PORTS];
    ppm_byte_type dd [`PPM_PORTS];
    ppm_byte_type dp [`PPM_PORTS];
    ppm_byte_type qo [`PPM_PORTS];
    ppm_byte_type qe [`PPM_PORTS];
    ppm_byte_type qp [`PPM_PORTS];

    // External low or any internal source resets the whole device
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            // Mode pin assumed pulled high until it is sampled
            state_reg <= '{
                rst_sync1: 1'b0,
                rst_sync2: 1'b0,
                mode_latched: 1'b1,
                bkgd_active: 1'b0,
                duty: PPM_MODE_SEL,
                port_out: '0,
                port_oen: '1,
                port_pu: '0
            };
        end else begin
            state_reg <= state_next;
        end
    end
    assign rst_n = state_reg.rst_sync2 & reset_pin_i;

    assign da = '{port_data_i.out_a, port_data_i.out_b, port_data_i.out_c};
    assign dd = '{port_dir_out_i.out_a, port_dir_out_i.out_b,
                  port_dir_out_i.out_c};
    assign dp = '{port_pullup_en_i.out_a, port_pullup_en_i.out_b,
                  port_pullup_en_i.out_c};

    function automatic logic is_od(input int p, input int b);
        is_od = (p == `PPM_PORT_A)
            && (b == `PPM_OD_DATA_BIT || b == `PPM_OD_CLOCK_BIT);
    endfunction

    genvar gp, gb;
    generate
        for (gp = 0; gp < `PPM_PORTS; gp++) begin : g_port
            for (gb = 0; gb < `PPM_PORT_W; gb++) begin : g_bit
                // Local bits keep each array bit to a single driver
                logic skip, drive_low, bo, be, bp;
                assign skip = (gp == `PPM_PORT_A)
                    && (gb == `PPM_OUT_ONLY_BIT);
                assign drive_low = dd[gp][gb] & ~da[gp][gb];
                always_comb begin
                    if (skip) begin
                        bo = 1'b0;
                        be = 1'b1;
                        bp = 1'b0;
                    end else if (is_od(gp, gb)) begin
                        // Never drive high; pad pulls low only
                        bo = 1'b0;
                        be = ~drive_low;
                        // Save power: pullup off while driving low
                        bp = two_wire_serial_unit_en_i
                            ? (dp[gp][gb] & ~drive_low)
                            : (dp[gp][gb] & ~dd[gp][gb]);
                    end else begin
                        bo = da[gp][gb];
                        be = ~dd[gp][gb];
                        bp = dp[gp][gb] & ~dd[gp][gb];
                    end
                end
                assign qo[gp][gb] = bo;
                assign qe[gp][gb] = be;
                assign qp[gp][gb] = bp;
            end
        end
    endgenerate

    always_comb begin
        state_next = state_reg;
        state_next.rst_sync1 = 1'b1;
        state_next.rst_sync2 = state_reg.rst_sync1;
        state_next.port_out = '{qo[0], qo[1], qo[2]};
        state_next.port_oen = '{qe[0], qe[1], qe[2]};
        state_next.port_pu = '{qp[0], qp[1], qp[2]};
        if (!rst_n || internal_reset_i) begin
            state_next.port_out = '0;
            state_next.port_oen = '1;
            state_next.port_pu = '0;
            // Pin released in every reset; mode resampled only on power-on or forced reset
            state_next.duty = PPM_MODE_SEL;
            if (por_or_force_i) begin
                state_next.mode_latched = background_mode_select_pin_i;
            end
        end else begin
            unique case (state_reg.duty)
                PPM_MODE_SEL: begin
                    state_next.duty = PPM_DEBUG;
                    // High selects normal mode, low active background
                    state_next.bkgd_active =
                        ~state_reg.mode_latched;
                end
                PPM_DEBUG, PPM_PORT: begin
                    state_next.duty = background_pin_enable_bit_i
                        ? PPM_DEBUG : PPM_PORT;
                end
            endcase
        end
    end

    // Reset pin is open drain; internal reset pulls it low
    assign reset_pin_o = 1'b0;
    assign reset_pin_oe_n_o = ~internal_reset_i;
    assign reset_pin_pullup_o = 1'b1;
    assign device_reset_n_o = rst_n & ~internal_reset_i;

    always_comb begin
        background_mode_select_pin_o = 1'b0;
        background_mode_select_pin_oe_n_o = 1'b1;
        bkgd_pullup_o = 1'b1;
        unique case (state_reg.duty)
            PPM_MODE_SEL: begin
                background_mode_select_pin_oe_n_o = 1'b1;
            end
            PPM_DEBUG: begin
                // Speedup pulse drives high briefly, else pseudo open drain
                background_mode_select_pin_o = bdc_speedup_i;
                background_mode_select_pin_oe_n_o =
                    ~(bdc_drive_low_i | bdc_speedup_i);
            end
            PPM_PORT: begin
                bkgd_pullup_o = 1'b0;
                background_mode_select_pin_o = comparator_output_sel_i
                    ? comparator_output_i : output_only_port_bit_i;
                background_mode_select_pin_oe_n_o = 1'b0;
            end
        endcase
    end

    // Receive path only in debug duty; link timing belongs to the controller
    assign bdc_rx_o = (state_reg.duty == PPM_DEBUG)
        & background_mode_select_pin_i;
    assign bdc_bit_cycles_o = `PPM_BIT_CYCLES;
    assign active_background_mode_o = state_reg.bkgd_active;

    assign port_pin_o = state_reg.port_out;
    assign port_oe_n_o = state_reg.port_oen;
    assign port_pullup_o = state_reg.port_pu;
    assign port_in_o = port_pin_i;

    assign crystal_oscillator_run_o =
        ~deep_stop_mode_i | osc_stop_enable_i;
endmodule

// ==== ppm_pad_ctrl_properties.sv ====
// Checker for the pad control block
`timescale 1ns/1ps
`include "ppm_map.svh"
module ppm_pad_ctrl_properties (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic internal_reset_i,
    input wire logic reset_pin_i,
    input wire logic reset_pin_o,
    input wire logic reset_pin_oe_n_o,
    input wire logic device_reset_n_o,
    input wire logic background_mode_select_pin_oe_n_o,
    input wire logic bkgd_pullup_o,
    input wire logic [4:0] bdc_bit_cycles_o,
    input wire ppm_pkg::ppm_ports_type port_dir_out_i,
    input wire ppm_pkg::ppm_ports_type port_pullup_en_i,
    input wire ppm_pkg::ppm_ports_type port_pin_o,
    input wire ppm_pkg::ppm_ports_type port_oe_n_o,
    input wire ppm_pkg::ppm_ports_type port_pullup_o,
    input wire logic osc_stop_enable_i,
    input wire logic deep_stop_mode_i,
    input wire logic crystal_oscillator_run_o
);
    import ppm_pkg::*;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    // Ports register one edge late, so two running cycles are needed
    sequence s_run;
        device_reset_n_o [*2];
    endsequence
    sequence s_held;
        !device_reset_n_o [*2];
    endsequence
    chk_reset_pin_drive: assert property (internal_reset_i |->
        !reset_pin_oe_n_o && !reset_pin_o) else $error("reset pin idle");
    chk_ext_reset_in: assert property (!reset_pin_i |->
        !device_reset_n_o) else $error("external reset ignored");
    chk_mode_pin_idle: assert property (s_held |->
        background_mode_select_pin_oe_n_o && bkgd_pullup_o)
        else $error("mode pin wrong in reset");
    chk_bit_length: assert property (
        bdc_bit_cycles_o == `PPM_BIT_CYCLES)
        else $error("bit length wrong");
    chk_od_low_only: assert property (
        (!port_oe_n_o.out_a[2] |-> !port_pin_o.out_a[2]) and
        (!port_oe_n_o.out_a[3] |-> !port_pin_o.out_a[3]))
        else $error("open drain high");
    chk_out_only_pull: assert property (!port_pullup_o.out_a[4])
        else $error("output only bit pulled");
    chk_pull_gate: assert property (s_run |->
        port_pullup_o.out_b ==
        ($past(port_pullup_en_i.out_b) & ~$past(port_dir_out_i.out_b)))
        else $error("port b pullup wrong");
    chk_reset_hiz: assert property (s_held |->
        &port_oe_n_o && !(|port_pullup_o)) else $error("ports not idle");
    chk_osc_stop: assert property (
        deep_stop_mode_i && osc_stop_enable_i |-> crystal_oscillator_run_o)
        else $error("oscillator stopped");
endmodule
bind ppm_pad_ctrl ppm_pad_ctrl_properties u_ppm_pad_ctrl_properties (.*);

// ==== ppm_pad_ctrl_test.sv ====
// Self-checking bench for the pad control block
`timescale 1ns/1ps
module ppm_pad_ctrl_test;
    import ppm_pkg::*;
    logic sys_clk_i = 0, resetn_i = 0, internal_reset_i = 0, rst_ext = 0;
    logic por_or_force_i = 1, hold = 0, reset_pin_i, reset_pin_o;
    logic reset_pin_oe_n_o, reset_pin_pullup_o, device_reset_n_o, lo;
    logic background_mode_select_pin_i, background_mode_select_pin_o;
    logic background_mode_select_pin_oe_n_o, bkgd_pullup_o, bdc_rx_o;
    logic background_pin_enable_bit_i = 1, bdc_drive_low_i = 0;
    logic bdc_speedup_i = 0, active_background_mode_o;
    logic [4:0] bdc_bit_cycles_o;
    logic comparator_output_sel_i = 0, comparator_output_i = 0;
    logic output_only_port_bit_i = 0, two_wire_serial_unit_en_i = 0;
    logic osc_stop_enable_i = 0, deep_stop_mode_i = 0;
    logic crystal_oscillator_run_o;
    ppm_ports_type port_data_i = '0, port_dir_out_i = '0;
    ppm_ports_type port_pullup_en_i = '0;
    ppm_ports_type port_pin_i, port_pin_o, port_oe_n_o, port_pullup_o;
    ppm_ports_type port_in_o, exp_pu, exp_oe, exp_po;
    logic [31:0] seed = 32'h5ec7;
    int fails = 0, total_checks = 0, cycles = 0;
    assign port_pin_i = port_data_i;
    assign reset_pin_i = !rst_ext && reset_pin_oe_n_o;
    ppm_pad_ctrl u_ppm_pad_ctrl (.*);
    ppm_pod u_ppm_pod (.hold_low_i(hold),
        .dev_o_i(background_mode_select_pin_o),
        .dev_oe_n_i(background_mode_select_pin_oe_n_o),
        .pad_o(background_mode_select_pin_i));
    always #25 sys_clk_i = ~sys_clk_i;
    task automatic check(input string n, input logic [31:0] s, e);
        total_checks++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %s exp %h seen %h", n, e, s);
        end
    endtask
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task automatic do_reset(input logic h);
        hold = h;
        resetn_i = 0;
        repeat (8) @(negedge sys_clk_i);
        resetn_i = 1;
        repeat (4) @(negedge sys_clk_i);
        hold = 0;
        repeat (2) @(negedge sys_clk_i);
        check("mode", active_background_mode_o, h);
    endtask
    task close_out;
        if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            close_out;
        end
    end
    initial begin
        do_reset(1);
        do_reset(0);
        hold = 1;
        @(negedge sys_clk_i);
        check("rx low", bdc_rx_o, 0);
        hold = 0;
        por_or_force_i = 0;
        internal_reset_i = 1;
        @(negedge sys_clk_i);
        check("rst oe", reset_pin_oe_n_o, 0);
        check("dev rst", device_reset_n_o, 0);
        internal_reset_i = 0;
        repeat (4) @(negedge sys_clk_i);
        check("rx high", bdc_rx_o, 1);
        port_dir_out_i = 24'hff0000;
        port_pullup_en_i = 24'hffffff;
        @(negedge sys_clk_i);
        rst_ext = 1;
        repeat (2) @(negedge sys_clk_i);
        check("ext rst", device_reset_n_o, 0);
        check("ext oe", reset_pin_oe_n_o, 1);
        check("hiz oe", port_oe_n_o, 24'hffffff);
        check("hiz pu", port_pullup_o, 24'h000000);
        check("ms oe", background_mode_select_pin_oe_n_o, 1);
        check("rst pu", reset_pin_pullup_o, 1);
        check("bit len", bdc_bit_cycles_o, 5'h10);
        rst_ext = 0;
        repeat (4) @(negedge sys_clk_i);
        check("mode kept", active_background_mode_o, 0);
        repeat (60) begin
            seed = xs(seed);
            port_data_i = seed[23:0];
            {two_wire_serial_unit_en_i, osc_stop_enable_i} = seed[25:24];
            {deep_stop_mode_i, background_pin_enable_bit_i} = seed[27:26];
            {comparator_output_sel_i, comparator_output_i} = seed[29:28];
            output_only_port_bit_i = seed[30];
            seed = xs(seed);
            port_dir_out_i = seed[23:0];
            seed = xs(seed);
            port_pullup_en_i = seed[23:0];
            @(negedge sys_clk_i);
            exp_pu = port_pullup_en_i & ~port_dir_out_i;
            exp_oe = ~port_dir_out_i;
            exp_pu.out_a[4] = 0;
            exp_oe.out_a[4] = 1;
            exp_po = port_data_i;
            exp_po.out_a[4:2] = 3'h0;
            for (int k = 2; k < 4; k++) begin
                lo = port_dir_out_i.out_a[k] & ~port_data_i.out_a[k];
                exp_oe.out_a[k] = ~lo;
                if (two_wire_serial_unit_en_i)
                    exp_pu.out_a[k] = port_pullup_en_i.out_a[k] & ~lo;
            end
            check("pullup", port_pullup_o, exp_pu);
            check("oe", port_oe_n_o, exp_oe);
            check("pin", port_pin_o, exp_po);
            check("in", port_in_o, port_data_i);
            check("osc", crystal_oscillator_run_o,
                !deep_stop_mode_i || osc_stop_enable_i);
            check("ms pu", bkgd_pullup_o,
                background_pin_enable_bit_i);
            check("ms pad", background_mode_select_pin_i,
                background_pin_enable_bit_i || (comparator_output_sel_i
                ? comparator_output_i : output_only_port_bit_i));
            check("rx", bdc_rx_o, background_pin_enable_bit_i);
        end
        close_out;
    end
endmodule

// ==== ppm_pkg.sv ====
// Types for the pin pad and mode select block
package ppm_pkg;
    typedef logic [7:0] ppm_byte_type;
    typedef struct packed {
        ppm_byte_type out_a;
        ppm_byte_type out_b;
        ppm_byte_type out_c;
    } ppm_ports_type;
    typedef enum logic [1:0] {PPM_MODE_SEL, PPM_DEBUG, PPM_PORT} ppm_duty_type;
    typedef struct packed {
        logic rst_sync1;
        logic rst_sync2;
        logic mode_latched;
        logic bkgd_active;
        ppm_duty_type duty;
        ppm_ports_type port_out;
        ppm_ports_type port_oen;
        ppm_ports_type port_pu;
    } ppm_state_type;
endpackage

// ==== ppm_pod.sv ====
// Debug pod model on the shared pin
`timescale 1ns/1ps
module ppm_pod (
    input wire logic hold_low_i,
    input wire logic dev_o_i,
    input wire logic dev_oe_n_i,
    output logic pad_o
);
    // Pseudo open drain: either side pulls low, pullup returns it high
    assign pad_o = !(hold_low_i || (!dev_oe_n_i && !dev_o_i));
endmodule
